// ---- shared/csopt_pkg.sv ----
// Constants, field layout and types of the chip select option block.
// Assumes a 100 MHz APB clock; used by the top module and the testbench.
package csopt_pkg;
  localparam int NUM_CS = 8;
  localparam int CS_IDX_W = 3;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OPTION_BASE = 12'h000;
  localparam logic [11:0] INT_STATUS_OFS = 12'h020;
  localparam logic [11:0] INT_CLEAR_OFS = 12'h024;
  localparam logic [11:0] INT_ENABLE_OFS = 12'h028;
  localparam logic [11:0] ACCESS_STATE_OFS = 12'h02C;
  // Option register fields
  localparam int PROTECT_BIT = 0;
  localparam int RW_SELECT_BIT = 1;
  localparam int WS_LSB = 2;
  localparam int WS_W = 5;
  localparam int EXTENDED_BURST_ENABLE_BIT = 8;
  localparam int RDHOLD_BIT = 9;
  localparam int EBI_LSB = 10;
  localparam int BW_LSB = 12;
  localparam logic [31:0] OPTION_MASK_CS7 = 32'h00003F7F;
  localparam logic [31:0] OPTION_MASK_OTHER = 32'h00003E7F;
  localparam logic [4:0] WS_EXTERNAL = 5'h1F;
  localparam logic [4:0] WS_RESET_CS0 = 5'h1E;
  localparam logic [4:0] WS_RESET_OTHER = 5'h00;
  localparam logic [1:0] EBI_SDRAM = 2'h1;
  localparam logic [2:0] SDRAM_CS = 3'h7;
  localparam logic [2:0] EXTENDED_BURST_ENABLE_CS = 3'h7;
  // Interrupt status bits
  localparam int INT_DONE = 0;
  localparam int INT_PROTECT = 1;
  localparam int INT_TIMEOUT = 2;
  localparam int INT_W = 3;
  // Bus timeout monitor
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_NS = 10240;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int TIMEOUT_W = 11;
  localparam logic [10:0] TIMEOUT_LAST = 11'(TIMEOUT_CYCLES - 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_HOLD = 2'b11
  } state_t;
endpackage : csopt_pkg

// ---- logic/sync2.sv ----
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/100ps
module sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync2

// ---- logic/wait_counter.sv ----
// Saturating cycle counter with match flag.
// Assumes clear and enable come from logic on pclk.
`timescale 1ns/100ps
module wait_counter #(
  parameter int W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic [W-1:0] target,
  output logic [W-1:0] count,
  output logic hit
);
  assign hit = enable && (count == target);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (enable && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end
endmodule : wait_counter

// ---- logic/chip_select_option_timing.sv ----
// Chip select option registers and access termination for eight selects.
// Assumes an internal requester on pclk and an APB master for software.
// Notes on behaviour
// - Read hold bit adds one address hold cycle.
// - Extended burst only on select seven.
// - Wait count field sets internal acknowledge delay.
// - Codes up to 0x1E end cycle internally.
// - Code 0x1F waits external acknowledge or times out.
// - SDRAM select with code 0x1F defers to controller.
// - Wait field resets 0x1E select zero, else zero.
// - Protect bit enables read-only or write-only region.
// - Direction conflict signals protect violation.
`timescale 1ns/100ps
module chip_select_option_timing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_req,
  input wire logic [2:0] acc_cs,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_size,
  output logic acc_busy,
  output logic acc_ack,
  output logic acc_error,
  input wire logic ext_xfer_ack_n,
  input wire logic sdram_done,
  output logic [7:0] cs_n,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic mem_read,
  output logic [1:0] mem_width,
  output logic addr_valid,
  output logic sdram_owner,
  output logic ext_burst,
  output logic protect_violation,
  output logic irq
);
  logic [31:0] option [csopt_pkg::NUM_CS];
  logic [csopt_pkg::INT_W-1:0] int_status;
  logic [csopt_pkg::INT_W-1:0] int_enable;
  csopt_pkg::state_t state;
  csopt_pkg::state_t next_state;
  logic [2:0] cur_cs;
  logic cur_write;
  logic [31:0] cur_opt;
  logic [31:0] req_opt;
  logic [4:0] cur_ws;
  logic cur_external;
  logic cur_sdram;
  logic req_conflict;
  logic take_req;
  logic ext_ack_sync_n;
  logic ext_ack;
  logic ws_hit;
  logic [4:0] ws_count;
  logic to_hit;
  logic terminate;
  logic timed_out;
  logic apb_wr;
  logic addr_is_option;
  logic [2:0] reg_idx;
  logic mapped;
  logic [csopt_pkg::INT_W-1:0] events;
  logic accept;
  logic req_sdram;
  logic req_burst;
  logic [7:0] next_cs_n;

  // Pin input synchronisation
  sync2 ack_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(ext_xfer_ack_n),
    .q(ext_ack_sync_n)
  );
  assign ext_ack = !ext_ack_sync_n;

  // APB decode
  assign apb_wr = psel && penable && pwrite;
  assign addr_is_option = (paddr[11:5] == csopt_pkg::OPTION_BASE[11:5]);
  assign reg_idx = paddr[4:2];
  assign pready = 1'b1;
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (addr_is_option) begin
        mapped = 1'b1;
      end else if (paddr == csopt_pkg::INT_STATUS_OFS) begin
        mapped = !pwrite;
      end else if (paddr == csopt_pkg::INT_CLEAR_OFS) begin
        mapped = pwrite;
      end else if (paddr == csopt_pkg::INT_ENABLE_OFS) begin
        mapped = 1'b1;
      end else if (paddr == csopt_pkg::ACCESS_STATE_OFS) begin
        mapped = !pwrite;
      end
    end
  end
  assign pslverr = psel && penable && !mapped;

  // Option registers, one per chip select
  genvar g;
  generate
    for (g = 0; g < csopt_pkg::NUM_CS; g++) begin : gen_opt
      localparam logic [4:0] WS_INIT = (g == 0) ?
        csopt_pkg::WS_RESET_CS0 : csopt_pkg::WS_RESET_OTHER;
      localparam logic [31:0] MASK = (g == csopt_pkg::EXTENDED_BURST_ENABLE_CS) ?
        csopt_pkg::OPTION_MASK_CS7 : csopt_pkg::OPTION_MASK_OTHER;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          option[g] <= 32'(WS_INIT) << csopt_pkg::WS_LSB;
        end else if (apb_wr && addr_is_option && paddr[1:0] == 2'b00
                     && reg_idx == 3'(g)) begin
          option[g] <= pwdata & MASK;
        end
      end
    end
  endgenerate

  // APB read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr[1:0] == 2'b00) begin
        if (addr_is_option) begin
          prdata <= option[reg_idx];
        end else if (paddr == csopt_pkg::INT_STATUS_OFS) begin
          prdata <= 32'(int_status);
        end else if (paddr == csopt_pkg::INT_ENABLE_OFS) begin
          prdata <= 32'(int_enable);
        end else if (paddr == csopt_pkg::ACCESS_STATE_OFS) begin
          prdata <= {19'h00000, ws_count, 3'h0, cur_cs, state};
        end
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= '0;
    end else if (apb_wr && paddr == csopt_pkg::INT_ENABLE_OFS) begin
      int_enable <= pwdata[csopt_pkg::INT_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else if (apb_wr && paddr == csopt_pkg::INT_CLEAR_OFS) begin
      int_status <= (int_status & ~pwdata[csopt_pkg::INT_W-1:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end
  assign irq = |(int_status & int_enable);

  // Request decode and protection check
  assign req_opt = option[acc_cs];
  always_comb begin
    req_conflict = 1'b0;
    if (req_opt[csopt_pkg::PROTECT_BIT]) begin
      req_conflict = req_opt[csopt_pkg::RW_SELECT_BIT] ? !acc_write
                                                        : acc_write;
    end
  end
  assign take_req = (state == csopt_pkg::ST_IDLE) && acc_req;
  assign acc_busy = (state != csopt_pkg::ST_IDLE);

  // Accepted request and the attributes handed to the memory side
  assign accept = take_req && !req_conflict;
  assign req_sdram = (acc_cs == csopt_pkg::SDRAM_CS)
    && (req_opt[csopt_pkg::WS_LSB +: csopt_pkg::WS_W]
        == csopt_pkg::WS_EXTERNAL)
    && (req_opt[csopt_pkg::EBI_LSB +: 2] == csopt_pkg::EBI_SDRAM);
  assign req_burst = (acc_cs == csopt_pkg::EXTENDED_BURST_ENABLE_CS)
    && req_opt[csopt_pkg::EXTENDED_BURST_ENABLE_BIT];

  // Select for the coming cycle, one-hot active low
  always_comb begin
    next_cs_n = 8'hFF;
    if (accept) begin
      next_cs_n = ~(8'h01 << acc_cs);
    end else if (next_state == csopt_pkg::ST_ACTIVE) begin
      next_cs_n = ~(8'h01 << cur_cs);
    end
  end

  // Current access option fields
  assign cur_opt = option[cur_cs];
  assign cur_ws = cur_opt[csopt_pkg::WS_LSB +: csopt_pkg::WS_W];
  assign cur_external = (cur_ws == csopt_pkg::WS_EXTERNAL);
  assign cur_sdram = (cur_cs == csopt_pkg::SDRAM_CS)
    && (cur_opt[csopt_pkg::EBI_LSB +: 2] == csopt_pkg::EBI_SDRAM);

  // Wait state counter, started at chip select assertion
  wait_counter #(
    .W(5)
  ) ws_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clear(state != csopt_pkg::ST_ACTIVE),
    .enable(state == csopt_pkg::ST_ACTIVE && !cur_external),
    .target(cur_ws),
    .count(ws_count),
    .hit(ws_hit)
  );

  // Bus timeout monitor for externally terminated cycles
  wait_counter #(
    .W(csopt_pkg::TIMEOUT_W)
  ) to_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clear(state != csopt_pkg::ST_ACTIVE),
    .enable(state == csopt_pkg::ST_ACTIVE && cur_external && !cur_sdram),
    .target(csopt_pkg::TIMEOUT_LAST),
    .count(),
    .hit(to_hit)
  );

  // Termination source selection
  always_comb begin
    terminate = 1'b0;
    timed_out = 1'b0;
    if (state == csopt_pkg::ST_ACTIVE) begin
      if (!cur_external) begin
        terminate = ws_hit;
      end else if (cur_sdram) begin
        terminate = sdram_done;
      end else if (ext_ack) begin
        terminate = 1'b1;
      end else if (to_hit) begin
        terminate = 1'b1;
        timed_out = 1'b1;
      end
    end
  end

  // Access sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      csopt_pkg::ST_IDLE: begin
        if (take_req && !req_conflict) begin
          next_state = csopt_pkg::ST_ACTIVE;
        end
      end
      csopt_pkg::ST_ACTIVE: begin
        if (terminate) begin
          if (!cur_write && cur_opt[csopt_pkg::RDHOLD_BIT]) begin
            next_state = csopt_pkg::ST_HOLD;
          end else begin
            next_state = csopt_pkg::ST_IDLE;
          end
        end
      end
      csopt_pkg::ST_HOLD: begin
        next_state = csopt_pkg::ST_IDLE;
      end
      default: begin
        next_state = csopt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= csopt_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Captured request; address and attributes stay through the hold cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_cs <= 3'h0;
      cur_write <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_size <= 2'h0;
    end else if (take_req && !req_conflict) begin
      cur_cs <= acc_cs;
      cur_write <= acc_write;
      mem_addr <= acc_addr;
      mem_size <= acc_size;
    end
  end

  // Memory side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n <= 8'hFF;
      addr_valid <= 1'b0;
      mem_read <= 1'b1;
      mem_width <= 2'h0;
      sdram_owner <= 1'b0;
      ext_burst <= 1'b0;
    end else begin
      cs_n <= next_cs_n;
      addr_valid <= (next_state != csopt_pkg::ST_IDLE);
      if (accept) begin
        mem_read <= !acc_write;
        mem_width <= req_opt[csopt_pkg::BW_LSB +: 2];
        sdram_owner <= req_sdram;
        ext_burst <= req_burst;
      end else if (next_state != csopt_pkg::ST_ACTIVE) begin
        sdram_owner <= 1'b0;
        ext_burst <= 1'b0;
      end
    end
  end

  // Requester answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ack <= 1'b0;
      acc_error <= 1'b0;
      protect_violation <= 1'b0;
    end else begin
      acc_ack <= terminate && !timed_out;
      acc_error <= timed_out || (take_req && req_conflict);
      protect_violation <= take_req && req_conflict;
    end
  end

  always_comb begin
    events = '0;
    events[csopt_pkg::INT_DONE] = terminate && !timed_out;
    events[csopt_pkg::INT_PROTECT] = take_req && req_conflict;
    events[csopt_pkg::INT_TIMEOUT] = timed_out;
  end
endmodule : chip_select_option_timing

// ---- dv/csopt_assertions.sv ----
// Checker of access termination, hold and protection at the top ports.
// Assumes binding to chip_select_option_timing from the testbench file.
`timescale 1ns/100ps
module csopt_assertions (
  input logic pclk,
  input logic presetn,
  input logic acc_req,
  input logic acc_busy,
  input logic acc_ack,
  input logic acc_error,
  input logic sdram_done,
  input logic [7:0] cs_n,
  input logic mem_read,
  input logic addr_valid,
  input logic sdram_owner,
  input logic ext_burst,
  input logic protect_violation
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold;
    addr_valid && &cs_n |-> mem_read && !$past(&cs_n);
  endproperty
  a_hold: assert property (p_hold) else $error("bad address hold");
  property p_onehot;
    $onehot0(~cs_n);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two selects");
  property p_ack;
    acc_ack |-> &cs_n && !$past(&cs_n);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not at end");
  property p_viol;
    protect_violation |-> acc_error && &cs_n;
  endproperty
  a_viol: assert property (p_viol) else $error("violation wrong");
  property p_excl;
    acc_error |-> !acc_ack;
  endproperty
  a_excl: assert property (p_excl) else $error("ack with error");
  property p_sdram;
    sdram_owner |-> !cs_n[7];
  endproperty
  a_sdram: assert property (p_sdram) else $error("owner off select");
  property p_burst;
    ext_burst |-> !cs_n[7];
  endproperty
  a_burst: assert property (p_burst) else $error("burst off select");
  property p_start;
    acc_req && !acc_busy |=> !(&cs_n) || acc_error;
  endproperty
  a_start: assert property (p_start) else $error("no select");
  property p_sdone;
    sdram_owner && sdram_done |-> ##[1:3] acc_ack;
  endproperty
  a_sdone: assert property (p_sdone) else $error("sdram end lost");
  c_hold: cover property (addr_valid && &cs_n);
  c_viol: cover property (protect_violation);
  c_sdone: cover property (sdram_owner && sdram_done);
endmodule : csopt_assertions

// ---- dv/mem_model.sv ----
// External memory side: drives the acknowledge pin and SDRAM done.
// Assumes registered active-low selects from the block.
`timescale 1ns/100ps
module mem_model (
  input logic pclk,
  input logic presetn,
  input logic [7:0] cs_n,
  input logic ack_en,
  output logic ext_xfer_ack_n,
  output logic sdram_done
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 4'h0;
    else if (&cs_n) cnt <= 4'h0;
    else if (cnt != 4'hF) cnt <= cnt + 4'h1;
  end
  // Acknowledge only for selects 0 to 6, released with the select
  assign ext_xfer_ack_n = !(ack_en && !(&cs_n[6:0])
                            && cnt >= 4'h3);
  assign sdram_done = !cs_n[7] && cnt == 4'h4;
endmodule : mem_model

// ---- dv/tb.sv ----
// Testbench: APB setup, row-driven accesses, then special cases.
// Assumes the block, the memory model and the checker are compiled.
`timescale 1ns/100ps
module tb;
  typedef struct {logic [2:0] cs; logic [4:0] ws; logic wr;
    logic [5:0] ex;} row_t;
  row_t rows [5] = '{'{3'h1, 5'h00, 1'h0, 6'h01}, '{3'h2, 5'h01, 1'h1, 6'h02},
    '{3'h5, 5'h0A, 1'h0, 6'h0B}, '{3'h6, 5'h1E, 1'h1, 6'h1F},
    '{3'h0, 5'h1E, 1'h0, 6'h1F}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic acc_req = 0, acc_write = 0, ack_en = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, acc_addr = '0, prdata, mem_addr, rd;
  logic [2:0] acc_cs = '0;
  logic [1:0] acc_size = '0, mem_size, mem_width;
  logic [7:0] cs_n;
  logic pready, pslverr, acc_busy, acc_ack, acc_error, ext_xfer_ack_n;
  logic sdram_done, mem_read, addr_valid, sdram_owner, ext_burst;
  logic protect_violation, irq, serr, ok, er, pv, sd, eb;
  int error_cnt = 0, samples_checked = 0, cyc = 0, csc, avc;
  always #5 pclk = ~pclk;
  chip_select_option_timing dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .acc_req, .acc_cs,
    .acc_write, .acc_addr, .acc_size, .acc_busy, .acc_ack, .acc_error,
    .ext_xfer_ack_n, .sdram_done, .cs_n, .mem_addr, .mem_size, .mem_read,
    .mem_width, .addr_valid, .sdram_owner, .ext_burst, .protect_violation,
    .irq);
  mem_model mem (.pclk, .presetn, .cs_n, .ack_en, .ext_xfer_ack_n,
    .sdram_done);
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task acc(input logic [2:0] c, input logic w);
    int n;
    @(posedge pclk);
    acc_req <= 1'h1;
    acc_cs <= c;
    acc_write <= w;
    acc_addr <= 32'h00001000;
    acc_size <= 2'h2;
    @(posedge pclk);
    acc_req <= 1'h0;
    {ok, er, pv, sd, eb} = 5'h0;
    csc = 0;
    avc = 0;
    n = 0;
    while (!ok && !er && n < 2000) begin
      @(negedge pclk);
      n++;
      csc += (cs_n !== 8'hFF);
      avc += (addr_valid === 1'h1);
      ok = (acc_ack === 1'h1);
      er = (acc_error === 1'h1);
      pv |= (protect_violation === 1'h1);
      sd |= (sdram_owner === 1'h1);
      eb |= (ext_burst === 1'h1);
    end
  endtask : acc
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      summarize;
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h00000078);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'h1, {7'h0, rows[i].cs, 2'h0}, {25'h0, rows[i].ws, 2'h0});
      acc(rows[i].cs, rows[i].wr);
      chk(32'(csc), 32'(rows[i].ex));
      chk({er, ok}, 2'h1);
    end
    $display("wait state rows done");
    apb(1'h1, 12'h008, 32'h00000204);
    acc(3'h2, 1'h0);
    chk(32'(avc), 32'h3);
    acc(3'h2, 1'h1);
    chk(32'(avc), 32'h2);
    $display("read hold test done");
    apb(1'h1, 12'h010, 32'h1);
    acc(3'h4, 1'h1);
    chk({er, pv, ok, 5'(csc)}, 8'hC0);
    acc(3'h4, 1'h0);
    chk({er, ok}, 2'h1);
    apb(1'h1, 12'h010, 32'h3);
    acc(3'h4, 1'h0);
    chk({er, pv}, 2'h3);
    acc(3'h4, 1'h1);
    chk({er, ok}, 2'h1);
    $display("protect test done");
    ack_en <= 1'h1;
    apb(1'h1, 12'h00C, 32'h100);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h01C, 32'h257C);
    apb(1'h0, 12'h01C, 32'h0);
    chk(rd, 32'h257C);
    acc(3'h7, 1'h0);
    chk({ok, er, sd, eb}, 4'hB);
    chk(mem_addr, 32'h00001000);
    chk({mem_width, mem_size}, 4'hA);
    $display("sdram test done");
    apb(1'h1, 12'h004, 32'h7C);
    acc(3'h1, 1'h0);
    chk({ok, er, csc > 3}, 3'h5);
    ack_en <= 1'h0;
    acc(3'h1, 1'h1);
    chk({ok, er}, 2'h1);
    chk(csc >= csopt_pkg::TIMEOUT_CYCLES - 1 &&
        csc <= csopt_pkg::TIMEOUT_CYCLES + 1, 1'h1);
    $display("external ack test done");
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, 32'h7);
    apb(1'h1, 12'h024, 32'h7);
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h028, 32'h0);
    acc(3'h3, 1'h0);
    @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h1, 12'h028, 32'h1);
    @(negedge pclk);
    chk(irq, 1'h1);
    apb(1'h1, 12'h024, 32'h1);
    @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h0, 12'h100, 32'h0);
    chk({serr, rd}, {1'h1, 32'h0});
    apb(1'h1, 12'h020, 32'h1);
    chk(serr, 1'h1);
    $display("interrupt and map test done");
    summarize;
  end
endmodule : tb
bind chip_select_option_timing csopt_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .acc_req(acc_req), .acc_busy(acc_busy),
  .acc_ack(acc_ack), .acc_error(acc_error), .sdram_done(sdram_done),
  .cs_n(cs_n), .mem_read(mem_read), .addr_valid(addr_valid),
  .sdram_owner(sdram_owner), .ext_burst(ext_burst),
  .protect_violation(protect_violation));
